// ===== inc/tccl_map.svh
// register offsets, field positions and reset values of the timer control
`ifndef TCCL_MAP_SVH
`define TCCL_MAP_SVH

`define TCCL_OFS_CONTROL    8'h00
`define TCCL_OFS_MODE       8'h04
`define TCCL_OFS_COUNT      8'h08
`define TCCL_OFS_CMP_A      8'h0c
`define TCCL_OFS_CMP_B      8'h10
`define TCCL_OFS_CMP_C      8'h14
`define TCCL_OFS_CMP_D      8'h18
`define TCCL_OFS_STATUS     8'h1c
`define TCCL_OFS_LAST       8'h1c
`define TCCL_IDX_CMP_A      3'h3

`define TCCL_BIT_CLEAR      7
`define TCCL_BIT_CKS_HI     6
`define TCCL_BIT_CKS_LO     4
`define TCCL_BIT_LEVEL_D    3
`define TCCL_BIT_LEVEL_C    2
`define TCCL_BIT_LEVEL_B    1
`define TCCL_BIT_RUN        7

`define TCCL_CONTROL_RESET  8'h00
`define TCCL_RUN_RESET      1'b0
`define TCCL_MODE_RSVD_ONES 8'h48
`define TCCL_COUNT_RESET    16'h0000
`define TCCL_CMP_RESET      16'hffff
`define TCCL_PIN_RESET      3'h0

`define TCCL_RESP_OKAY      2'h0
`define TCCL_RESP_DECERR    2'h3

`endif

// ===== inc/tccl_pkg.sv
// types shared by the timer control modules
package tccl_pkg;
    typedef logic [15:0] tccl_count_t;
    typedef logic [7:0]  tccl_addr_t;
    typedef enum logic [2:0]
    {
        TCCL_CKS_SYS  = 3'h0,
        TCCL_CKS_DIV2 = 3'h1,
        TCCL_CKS_DIV4 = 3'h2,
        TCCL_CKS_DIV8 = 3'h3,
        TCCL_CKS_EXT  = 3'h4
    } tccl_cks_t;
endpackage

// ===== inc/tccl_tick_if.sv
// carrier for clock selection and the resulting count tick
`timescale 1ns/100ps
interface tccl_tick_if;
    logic [2:0] clockSelect;
    logic       subclockMode;
    logic       countTick;
    modport gen  (input clockSelect, input subclockMode, output countTick);
    modport ctrl (output clockSelect, output subclockMode, input countTick);
endinterface

// ===== verilog/tccl_tick_gen.sv
// count tick source: prescaler, subclock and external event edges
`timescale 1ns/100ps
`include "tccl_map.svh"
module tccl_tick_gen
    import tccl_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic externalEventInput,
    input  wire logic subclockInput,
    tccl_tick_if.gen  tick
);
    logic [2:0] extSync_r;
    logic [2:0] subSync_r;
    logic       extLevel_r;
    logic       subLevel_r;
    logic       extPrev_r;
    logic       subPrev_r;
    logic [2:0] divCnt_r;

    // a level only counts once the two later stages agree
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            extSync_r  <= 3'h0;
            subSync_r  <= 3'h0;
            extLevel_r <= 1'b0;
            subLevel_r <= 1'b0;
            extPrev_r  <= 1'b0;
            subPrev_r  <= 1'b0;
        end
        else
        begin
            extSync_r <= {extSync_r[1:0], externalEventInput};
            subSync_r <= {subSync_r[1:0], subclockInput};
            if (extSync_r[1] == extSync_r[2])
                extLevel_r <= extSync_r[2];
            if (subSync_r[1] == subSync_r[2])
                subLevel_r <= subSync_r[2];
            extPrev_r <= extLevel_r;
            subPrev_r <= subLevel_r;
        end
    end

    // free-running prescaler, shared by all divided rates
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            divCnt_r <= 3'h0;
        else
            divCnt_r <= divCnt_r + 3'h1;
    end

    wire extRise = extLevel_r & ~extPrev_r;
    wire subRise = subLevel_r & ~subPrev_r;
    wire [2:0] sel = tick.clockSelect;
    wire sysTick = tick.subclockMode ? subRise : 1'b1;            // RQ5
    wire [1:0] selLo = sel[1:0];
    wire divTick = (selLo == 2'(TCCL_CKS_SYS))  ? sysTick :       // RQ3
                   (selLo == 2'(TCCL_CKS_DIV2)) ? divCnt_r[0] :
                   (selLo == 2'(TCCL_CKS_DIV4)) ? &divCnt_r[1:0] :
                   &divCnt_r;
    assign tick.countTick = sel[2] ? extRise : divTick;           // RQ4
endmodule // tccl_tick_gen

// ===== verilog/tccl_top.sv
// timer clock select, clear-on-match and initial output level control
// Overview of operation
// RQ1: with the clear bit set, a channel A compare match zeroes the count.
// RQ2: with the clear bit low, the counter runs free and no match clears it.
// RQ3: clock select 000/001/010/011 counts clk, clk/2, clk/4, clk/8.
// RQ4: clock select 1xx counts rising edges of the external event input.
// RQ5: on the undivided clock in subclock mode, subclock edges are counted.
// RQ6: initial level bit 3 drives channel D until its first compare match.
// RQ7: initial level bit 2 drives channel C until its first compare match.
// RQ8: initial level bit 1 drives channel B until its first compare match.
// RQ9: the counter advances only while the run bit is 1, else it holds.
// RQ10: all control fields reset to zero.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "tccl_map.svh"
module tccl_top
    import tccl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        externalEventInput,
    input  wire logic        subclockInput,
    input  wire logic        subclockMode,
    output logic             channelBPin,
    output logic             channelCPin,
    output logic             channelDPin
);
    tccl_tick_if tickIf ();

    logic        awHeld_r;
    logic        wHeld_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    tccl_addr_t  waddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic [7:0]  control_r;
    logic [7:0]  control_nxt;
    logic        counterRun_r;
    tccl_count_t count_r;
    tccl_count_t count_nxt;
    tccl_count_t cmp_r [4];
    logic [2:0]  pin_r;
    logic [2:0]  pin_nxt;
    logic [3:0]  wrCmp;
    logic [3:0]  matchEv;

    function automatic logic addrMapped(input tccl_addr_t a);
        addrMapped = (a[1:0] == 2'h0) && (a <= `TCCL_OFS_LAST);
    endfunction

    function automatic tccl_count_t merge16(input tccl_count_t old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    tccl_tick_gen u_tickGen
    (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .externalEventInput (externalEventInput),
        .subclockInput      (subclockInput),
        .tick               (tickIf.gen)
    );

    assign tickIf.clockSelect  = control_r[`TCCL_BIT_CKS_HI:`TCCL_BIT_CKS_LO];
    assign tickIf.subclockMode = subclockMode;

    // write channel: address and data are held until both are in
    assign awready = ~awHeld_r & ~bvalid_r;
    assign wready  = ~wHeld_r & ~bvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    wire doWrite   = awHeld_r & wHeld_r & ~bvalid_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= `TCCL_RESP_OKAY;
            waddr_r  <= 8'h00;
            wdata_r  <= 32'h00000000;
            wstrb_r  <= 4'h0;
        end
        else
        begin
            if (awvalid & awready)
            begin
                awHeld_r <= 1'b1;
                waddr_r  <= awaddr;
            end
            else if (doWrite)
                awHeld_r <= 1'b0;
            if (wvalid & wready)
            begin
                wHeld_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            else if (doWrite)
                wHeld_r <= 1'b0;
            if (doWrite)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= addrMapped(waddr_r) ? `TCCL_RESP_OKAY
                                                : `TCCL_RESP_DECERR;
            end
            else if (bready)
                bvalid_r <= 1'b0;
        end
    end

    wire wrLow     = doWrite & wstrb_r[0];
    wire wrControl = wrLow & (waddr_r == `TCCL_OFS_CONTROL);
    wire wrMode    = wrLow & (waddr_r == `TCCL_OFS_MODE);
    wire wrCount   = doWrite & (|wstrb_r[1:0])
                   & (waddr_r == `TCCL_OFS_COUNT);

    // bit 0 of control has no function and stays zero
    assign control_nxt = wrControl ? {wdata_r[7:1], 1'b0} : control_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            control_r    <= `TCCL_CONTROL_RESET;                  // RQ10
            counterRun_r <= `TCCL_RUN_RESET;
        end
        else
        begin
            control_r <= control_nxt;
            if (wrMode)
                counterRun_r <= wdata_r[`TCCL_BIT_RUN];
        end
    end

    genvar g;
    for (g = 0; g < 4; g++)
    begin : gCmp
        assign wrCmp[g] = doWrite & (|wstrb_r[1:0]) & (waddr_r[7:5] == 3'h0)
                        & (waddr_r[1:0] == 2'h0)
                        & (waddr_r[4:2] == 3'(`TCCL_IDX_CMP_A + 3'(g)));
        assign matchEv[g] = counterRun_r & tickIf.countTick
                          & (count_r == cmp_r[g]);
        always_ff @(posedge clk_sys)
        begin
            if (reset)
                cmp_r[g] <= `TCCL_CMP_RESET;
            else if (wrCmp[g])
                cmp_r[g] <= merge16(cmp_r[g], wdata_r, wstrb_r);
        end
    end

    // software write wins over counting; clear wins over increment
    wire clearNow = control_r[`TCCL_BIT_CLEAR] & matchEv[0];      // RQ1 RQ2
    wire countEn  = counterRun_r & tickIf.countTick;              // RQ9
    assign count_nxt = wrCount  ? merge16(count_r, wdata_r, wstrb_r) :
                       clearNow ? `TCCL_COUNT_RESET :
                       countEn  ? count_r + 16'h0001 :
                       count_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            count_r <= `TCCL_COUNT_RESET;
        else
            count_r <= count_nxt;
    end

    // a control write sets the levels; later matches toggle them
    for (g = 0; g < 3; g++)
    begin : gPin
        assign pin_nxt[g] = wrControl      ? wdata_r[`TCCL_BIT_LEVEL_B + g] :
                            matchEv[g + 1] ? ~pin_r[g] :
                            pin_r[g];                             // RQ6 RQ7 RQ8
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pin_r <= `TCCL_PIN_RESET;                             // RQ10
        else
            pin_r <= pin_nxt;
    end

    assign channelBPin = pin_r[0];
    assign channelCPin = pin_r[1];
    assign channelDPin = pin_r[2];

    // read channel: one read in flight, answered one cycle later
    wire [31:0] rdValue =
        (araddr == `TCCL_OFS_CONTROL) ? {24'h000000, control_r} :
        (araddr == `TCCL_OFS_MODE)    ? {24'h000000,
            `TCCL_MODE_RSVD_ONES | {counterRun_r, 7'h00}} :
        (araddr == `TCCL_OFS_COUNT)   ? {16'h0000, count_r} :
        (araddr == `TCCL_OFS_CMP_A)   ? {16'h0000, cmp_r[0]} :
        (araddr == `TCCL_OFS_CMP_B)   ? {16'h0000, cmp_r[1]} :
        (araddr == `TCCL_OFS_CMP_C)   ? {16'h0000, cmp_r[2]} :
        (araddr == `TCCL_OFS_CMP_D)   ? {16'h0000, cmp_r[3]} :
        (araddr == `TCCL_OFS_STATUS)  ? {29'h0, pin_r} :
        32'h00000000;

    assign arready = ~rvalid_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `TCCL_RESP_OKAY;
        end
        else if (arvalid & arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdValue;
            rresp_r  <= addrMapped(araddr) ? `TCCL_RESP_OKAY
                                           : `TCCL_RESP_DECERR;
        end
        else if (rready)
            rvalid_r <= 1'b0;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    wire tick = tickIf.countTick;

    a_clear_on_match: assert property (clearNow && !wrCount |=> // RQ1
        count_r == 16'h0000) else $error("count not cleared on match A");
    a_free_running: assert property (countEn && !clearNow && !wrCount // RQ2
        |=> count_r == 16'($past(count_r) + 16'h0001))
        else $error("count did not advance by one");
    a_div_two_rate: assert property (control_r[6:4] == 3'h1 // RQ3
        && $past(control_r[6:4]) == 3'h1 |-> tick != $past(tick))
        else $error("divide by two tick not alternating");
    a_ext_edge_only: assert property (control_r[6] && tick // RQ4
        |=> !(control_r[6] && tick))
        else $error("external tick without a new edge");
    a_sys_every_cycle: assert property (control_r[6:4] == 3'h0 // RQ3
        && !subclockMode |-> tick) else $error("system clock tick missing");
    a_count_hold: assert property (!counterRun_r && !wrCount // RQ9
        |=> $stable(count_r)) else $error("stopped counter moved");
    a_level_d_load: assert property (wrControl // RQ6
        |=> channelDPin == $past(wdata_r[3]))
        else $error("channel D level not loaded");
    a_level_c_load: assert property (wrControl // RQ7
        |=> channelCPin == $past(wdata_r[2]))
        else $error("channel C level not loaded");
    a_level_b_match: assert property (!wrControl && matchEv[1] // RQ8
        |=> channelBPin != $past(channelBPin))
        else $error("channel B did not change on match");
    a_reset_zero: assert property ($past(reset) // RQ10
        |-> control_r == 8'h00 && pin_r == 3'h0)
        else $error("control not zero after reset");

    c_clear_event: cover property (clearNow);
    c_ext_tick:    cover property (control_r[6] && countEn);
    c_write_done:  cover property (bvalid && bready);
    c_read_done:   cover property (rvalid && rready);
endmodule // tccl_top

// ===== tb/tccl_event_src.sv
// far-side model: a square-wave event source on one pin
`timescale 1ns/100ps
module tccl_event_src
#(
    parameter int HALF = 4
)
(
    input  wire logic clk_sys,
    input  wire logic reset,
    output logic      eventPin
);
    int phase;
    // pin held low in reset so no stray edge is counted
    always @(posedge clk_sys)
    begin
        phase <= (reset || phase == HALF - 1) ? 0 : phase + 1;
        if (reset)
            eventPin <= 1'b0;
        else if (phase == HALF - 1)
            eventPin <= !eventPin;
    end
endmodule // tccl_event_src

// ===== tb/test_tccl_top.sv
// self-checking bench for the timer control block
`timescale 1ns/100ps
`include "tccl_map.svh"
module test_tccl_top
    import tccl_pkg::*;
;
    logic        clk_sys, reset, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, subclockMode;
    logic        externalEventInput, subclockInput;
    logic        channelBPin, channelCPin, channelDPin;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd, held;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    int          n_errors, checks, seed, k, wc, n, i;
    int          cyc = 0;

    tccl_top u_tccl_top (.clk_sys, .reset, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .externalEventInput, .subclockInput, .subclockMode, .channelBPin,
        .channelCPin, .channelDPin);
    tccl_event_src u_ext (.clk_sys, .reset, .eventPin(externalEventInput));
    // slower subclock rate so a swapped source shows up in the counts
    tccl_event_src #(.HALF(6)) u_sub (.clk_sys, .reset,
        .eventPin(subclockInput));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkRange(input logic [31:0] got, input int lo, input int hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, lo);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int t;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        t = 0;
        do
        begin
            @(posedge clk_sys);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && t < 40);
        chk(bvalid, 32'h1);
        chk(bresp, er);
        wc = cyc;
        bready <= 1'b0;
    endtask

    task automatic rdReg(input logic [7:0] a);
        int t;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 0;
        do
        begin
            @(posedge clk_sys);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && t < 40);
        chk(rvalid, 32'h1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // k = clock cycles with the run bit set, measured between write answers
    task automatic runK(input logic [31:0] ctrl, input int cycles);
        int c1;
        wr(`TCCL_OFS_CONTROL, ctrl, `TCCL_RESP_OKAY);
        wr(`TCCL_OFS_COUNT, 32'h0, `TCCL_RESP_OKAY);
        wr(`TCCL_OFS_MODE, 32'h80, `TCCL_RESP_OKAY);
        c1 = wc;
        repeat (cycles) @(posedge clk_sys);
        wr(`TCCL_OFS_MODE, 32'h0, `TCCL_RESP_OKAY);
        k = wc - c1;
        rdReg(`TCCL_OFS_COUNT);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        results();
    end

    initial
    begin
        seed = 32'h17fd;
        n_errors = 0;
        checks = 0;
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, subclockMode} = 6'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        rdReg(`TCCL_OFS_CONTROL);
        chk(rd, 32'h0);
        chk({channelDPin, channelCPin, channelBPin}, 32'h0);
        rdReg(`TCCL_OFS_MODE);
        chk(rd, 32'h48);
        wr(8'h20, $random(seed), `TCCL_RESP_DECERR);
        rdReg(8'h02);
        chk(rs, `TCCL_RESP_DECERR);
        chk(rd, 32'h0);
        $display("test reset and decode done");
        // prescaler phase is free, so divided counts may land one high
        for (i = 0; i < 4; i++)
        begin
            n = 40 + ($random(seed) & 31);
            runK(i << 4, n);
            chkRange(rd, k >> i, (k + (1 << i) - 1) >> i);
        end
        held = rd;
        repeat (20) @(posedge clk_sys);
        rdReg(`TCCL_OFS_COUNT);
        chk(rd, held);
        $display("test internal clocks done");
        for (i = 4; i < 8; i++)
        begin
            runK(i << 4, 60);
            chkRange(rd, k / 8 - 1, k / 8 + 1);
        end
        subclockMode <= 1'b1;
        runK(32'h0, 60);
        chkRange(rd, k / 12 - 1, k / 12 + 1);
        subclockMode <= 1'b0;
        $display("test event and subclock done");
        wr(`TCCL_OFS_CMP_A, 32'h3, `TCCL_RESP_OKAY);
        n = 30 + ($random(seed) & 15);
        runK(32'h80, n);
        chk(rd, k % 4);
        runK(32'h00, n);
        chk(rd, k);
        $display("test clear on match done");
        for (i = 0; i < 8; i++)
        begin
            n = ($random(seed) & 32'hf0) | (i << 1);
            wr(`TCCL_OFS_CONTROL, n, `TCCL_RESP_OKAY);
            chk({channelDPin, channelCPin, channelBPin}, i);
            rdReg(`TCCL_OFS_CONTROL);
            chk(rd, n);
            rdReg(`TCCL_OFS_STATUS);
            chk(rd, i);
        end
        wr(`TCCL_OFS_CMP_B, 32'h5, `TCCL_RESP_OKAY);
        wr(`TCCL_OFS_CMP_C, 32'h7, `TCCL_RESP_OKAY);
        wr(`TCCL_OFS_CMP_D, 32'h9, `TCCL_RESP_OKAY);
        rdReg(`TCCL_OFS_CMP_B);
        chk(rd, 32'h5);
        // levels D=1 C=0 B=1, then one match each flips all three
        runK(32'h0a, 30);
        chk({channelDPin, channelCPin, channelBPin}, 32'h2);
        $display("test initial levels done");
        results();
    end
endmodule // test_tccl_top
